// >>> core/dec_params.svh
// constants for the cipher control register front end
`ifndef DEC_PARAMS_SVH
`define DEC_PARAMS_SVH
// =====================================================
// register offsets
`define DEC_OFF_CONTROL      8'hc3
`define DEC_OFF_KEY_PTR      8'hc4
`define DEC_OFF_DATA_PTR     8'hc5
`define DEC_OFF_BYTE_COUNT   8'hc6
`define DEC_OFF_IRQ_STATUS   8'hc8
`define DEC_OFF_IRQ_MASK     8'hc9
`define DEC_OFF_EXT_ENABLE   8'hca
// =====================================================
// control field positions
`define DEC_BIT_START        0
`define DEC_BIT_TRIPLE       1
`define DEC_BIT_DIR          2
`define DEC_BIT_MODE         3
`define DEC_BIT_RELOAD       4
`define DEC_BIT_DONE         5
`define DEC_BIT_IE           6
// =====================================================
// reset values and counts
`define DEC_RST_BYTE         8'h00
`define DEC_KEY_BYTES        3'h7
`define DEC_START_CYCLES     4'h2
`define DEC_ROUND_CYCLES     5'h19
`endif

// >>> core/dec_pkg.sv
// types for the cipher control register front end
`default_nettype none
package dec_pkg;
    // =====================================================
    // sequencer states
    typedef enum logic [4:0] {
        DEC_IDLE  = 5'h01,
        DEC_SETUP = 5'h02,
        DEC_KEY   = 5'h04,
        DEC_DATA  = 5'h08,
        DEC_WBACK = 5'h10
    } dec_state_e;
endpackage : dec_pkg
`default_nettype wire

// >>> core/dec_counter.sv
// loadable down counter with zero flag
`default_nettype none
module dec_counter #(
    parameter int WIDTH = 8
) (
    input  wire logic             core_clk_in,   // core clock
    input  wire logic             rst_n_in,      // sync reset, low
    input  wire logic             load_in,       // load value
    input  wire logic [WIDTH-1:0] value_in,      // value to load
    input  wire logic             dec_in,        // count down
    output logic      [WIDTH-1:0] count_out,     // current count
    output logic                  zero_out       // count is zero
);
    initial begin
        if (WIDTH < 1) $error("dec_counter width too small");
    end
    // =====================================================
    // counter
    logic [WIDTH-1:0] cnt_reg;  // count
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            cnt_reg <= '0;
        end else if (load_in) begin
            cnt_reg <= value_in;
        end else if (dec_in) begin
            cnt_reg <= cnt_reg - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
    assign count_out = cnt_reg;
    assign zero_out  = (cnt_reg == '0);
endmodule : dec_counter
`default_nettype wire

// >>> core/dec_flag.sv
// sticky flag, set wins over clear
`default_nettype none
module dec_flag (
    input  wire logic core_clk_in,   // core clock
    input  wire logic rst_n_in,      // sync reset, low
    input  wire logic set_in,        // hardware set
    input  wire logic clr_in,        // software clear
    output logic      flag_out       // flag state
);
    // =====================================================
    // flag register
    logic flag_reg;  // sticky bit
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            flag_reg <= 1'b0;
        end else if (set_in) begin
            flag_reg <= 1'b1;
        end else if (clr_in) begin
            flag_reg <= 1'b0;
        end
    end
    assign flag_out = flag_reg;
endmodule : dec_flag
`default_nettype wire

// >>> core/dec_engine_ctrl.sv
// cipher control registers and run sequencer
//
// How it works
// - writing one to start begins a run
// - start ignores zero, hardware clears at end
// - every run completion sets the done flag
// - done flag stays until software clears it
// - irq needs shared enable, local enable only on the done flag terms
// - no reload keeps previous key bytes
// - reload fetches key from key pointer
// - mode bit zero output, one cipher feedback
// - direction zero encrypts, one decrypts
// - key pointer gives upper address bits
// - data pointer upper bits, low bits zero
// - byte count zero means 256 bytes
// - key is seven consecutive bytes
// - processed byte written back in place
// - local enable also sets shared flag
//
// The strobed register port was decided locally.

`include "dec_params.svh"
`default_nettype none
module dec_engine_ctrl #(
    parameter int ADDR_W = 11
) (
    input  wire logic              core_clk_in,    // core clock
    input  wire logic              rst_n_in,       // sync reset, low
    input  wire logic [7:0]        reg_addr_in,    // register address
    input  wire logic [7:0]        reg_wdata_in,   // write data
    input  wire logic              reg_wr_in,      // write strobe
    input  wire logic              reg_rd_in,      // read strobe
    output logic      [7:0]        reg_rdata_out,  // read data, next cycle
    output logic      [ADDR_W-1:0] ram_addr_out,   // ram address
    output logic                   ram_rd_out,     // ram read strobe
    output logic                   ram_wr_out,     // ram write strobe
    output logic      [7:0]        ram_wdata_out,  // ram write data
    input  wire logic [7:0]        ram_rdata_in,   // ram read data, next cycle
    output logic                   ram_grant_in_n_unused_out, // tied low
    input  wire logic              ram_stall_in,   // ram busy with cpu
    output logic                   key_load_out,   // key byte strobe
    output logic      [2:0]        key_index_out,  // key byte index
    output logic      [7:0]        key_byte_out,   // key byte value
    output logic                   mode_cfb_out,   // feedback mode
    output logic                   decrypt_out,    // direction
    output logic                   busy_out,       // run in progress
    output logic                   irq_out         // interrupt level
);
    // refuse unusable widths
    initial begin
        if (ADDR_W != 11) $error("dec_engine_ctrl needs 11 address bits");
    end

    // =====================================================
    // register state
    // control bits
    logic       start_reg;      // start and busy
    logic       ie_reg;         // local irq enable
    logic       reload_reg;     // key reload select
    logic       mode_reg;       // feedback mode
    logic       dir_reg;        // direction
    logic       triple_reg;     // reserved triple bit
    // pointers and count
    logic [7:0] key_ptr_reg;    // key pointer
    logic [7:0] data_ptr_reg;   // data pointer
    logic [7:0] count_reg;      // byte count
    logic [1:0] mask_reg;       // irq mask
    logic       ext_en_reg;     // shared irq enable
    // data and flags
    logic [7:0] rdata_reg;      // read data
    logic       done_flag;      // done flag
    logic       ext_flag;       // shared irq flag
    logic       ev_done;        // run done event
    logic [7:0] key_store [0:6]; // held key bytes

    // =====================================================
    // sequencer state
    dec_pkg::dec_state_e state_reg;   // current state
    dec_pkg::dec_state_e state_next;  // next state
    logic [2:0] idx_reg;      // key byte index
    logic [7:0] byte_reg;     // data byte index
    logic [4:0] wait_reg;     // cycle wait
    logic [7:0] data_reg;     // byte in flight
    logic       rd_pend_reg;  // ram data due

    // =====================================================
    // address decode
    // write strobes
    wire wr_ctrl  = reg_wr_in && (reg_addr_in == `DEC_OFF_CONTROL);
    wire wr_key   = reg_wr_in && (reg_addr_in == `DEC_OFF_KEY_PTR);
    wire wr_data  = reg_wr_in && (reg_addr_in == `DEC_OFF_DATA_PTR);
    wire wr_cnt   = reg_wr_in && (reg_addr_in == `DEC_OFF_BYTE_COUNT);
    wire wr_stat  = reg_wr_in && (reg_addr_in == `DEC_OFF_IRQ_STATUS);
    wire wr_mask  = reg_wr_in && (reg_addr_in == `DEC_OFF_IRQ_MASK);
    wire wr_ext   = reg_wr_in && (reg_addr_in == `DEC_OFF_EXT_ENABLE);
    // start accepted only when idle and bit is one
    wire go = wr_ctrl && reg_wdata_in[`DEC_BIT_START] && !start_reg;
    // done flag cleared by writing zero to it, set wins
    wire clr_done = (wr_ctrl && !reg_wdata_in[`DEC_BIT_DONE])
                    || (wr_stat && reg_wdata_in[0]);
    wire clr_ext  = wr_stat && reg_wdata_in[1];
    wire set_ext  = ev_done && ie_reg;
    // control as read
    wire [7:0] ctrl_view = {1'b0, ie_reg, done_flag, reload_reg,
                            mode_reg, dir_reg, triple_reg, start_reg};
    // read select, unmapped zero
    wire [7:0] rd_mux =
        (reg_addr_in == `DEC_OFF_CONTROL)    ? ctrl_view :
        (reg_addr_in == `DEC_OFF_KEY_PTR)    ? key_ptr_reg :
        (reg_addr_in == `DEC_OFF_DATA_PTR)   ? data_ptr_reg :
        (reg_addr_in == `DEC_OFF_BYTE_COUNT) ? count_reg :
        (reg_addr_in == `DEC_OFF_IRQ_STATUS) ? {6'h00, ext_flag, done_flag} :
        (reg_addr_in == `DEC_OFF_IRQ_MASK)   ? {6'h00, mask_reg} :
        (reg_addr_in == `DEC_OFF_EXT_ENABLE) ? {7'h00, ext_en_reg} :
        `DEC_RST_BYTE;

    // =====================================================
    // sticky flags
    dec_flag u_done (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .set_in      (ev_done),
        .clr_in      (clr_done),
        .flag_out    (done_flag)
    );
    dec_flag u_ext (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .set_in      (set_ext),
        .clr_in      (clr_ext),
        .flag_out    (ext_flag)
    );

    // =====================================================
    // byte counter, zero count runs 256 bytes
    logic [8:0] left_cnt;   // bytes still to do
    logic       left_zero;  // no bytes left
    wire [8:0] run_len = (count_reg == 8'h00) ? 9'h100 : {1'b0, count_reg};
    // byte written back
    wire       byte_done = (state_reg == dec_pkg::DEC_WBACK) && !ram_stall_in;
    // run length at start
    dec_counter #(.WIDTH(9)) u_left (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .load_in     (go),
        .value_in    (run_len),
        .dec_in      (byte_done),
        .count_out   (left_cnt),
        .zero_out    (left_zero)
    );

    // =====================================================
    // sequencer next state
    // last write back due
    wire last_byte = (left_cnt == 9'h001);
    // next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            dec_pkg::DEC_IDLE: begin
                // wait for start
                if (go) begin
                    state_next = dec_pkg::DEC_SETUP;
                end
            end
            dec_pkg::DEC_SETUP: begin
                // setup wait
                if (wait_reg == 5'h00) begin
                    // reload picks key fetch, else old key kept
                    state_next = reload_reg ? dec_pkg::DEC_KEY
                                            : dec_pkg::DEC_DATA;
                end
            end
            dec_pkg::DEC_KEY: begin
                // last key byte
                if (rd_pend_reg && idx_reg == (`DEC_KEY_BYTES - 3'h1)) begin
                    state_next = dec_pkg::DEC_DATA;
                end
            end
            dec_pkg::DEC_DATA: begin
                // round over
                if (rd_pend_reg && wait_reg == 5'h00) begin
                    state_next = dec_pkg::DEC_WBACK;
                end
            end
            dec_pkg::DEC_WBACK: begin
                // ram not busy
                if (!ram_stall_in) begin
                    state_next = last_byte ? dec_pkg::DEC_IDLE : dec_pkg::DEC_DATA;
                end
            end
            default: begin
                // back to idle
                state_next = dec_pkg::DEC_IDLE;
            end
        endcase
    end
    // run ends here
    assign ev_done = byte_done && last_byte;

    // =====================================================
    // ram addressing: pointers give upper eight bits
    wire [ADDR_W-1:0] key_addr  = {key_ptr_reg, idx_reg};
    wire [ADDR_W-1:0] data_addr = {data_ptr_reg, 3'h0}
                                  + {3'h0, byte_reg};
    // one read at a time
    wire key_rd  = (state_reg == dec_pkg::DEC_KEY) && !rd_pend_reg && !ram_stall_in;
    wire data_rd = (state_reg == dec_pkg::DEC_DATA) && !rd_pend_reg && !ram_stall_in;
    // key address while fetching
    assign ram_addr_out  = (state_reg == dec_pkg::DEC_KEY) ? key_addr : data_addr;
    assign ram_rd_out    = key_rd || data_rd;
    assign ram_wr_out    = byte_done;
    assign ram_wdata_out = data_reg;
    assign ram_grant_in_n_unused_out = 1'b0;

    // =====================================================
    // sequencer registers
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            // idle, none due
            state_reg   <= dec_pkg::DEC_IDLE;
            idx_reg     <= 3'h0;
            byte_reg    <= 8'h00;
            wait_reg    <= 5'h00;
            rd_pend_reg <= 1'b0;
            data_reg    <= 8'h00;
        end else begin
            state_reg <= state_next;
            // start clears indices
            if (go) begin
                idx_reg  <= 3'h0;
                byte_reg <= 8'h00;
                wait_reg <= {1'b0, `DEC_START_CYCLES} - 5'h1;
            end else if (wait_reg != 5'h00) begin
                // count down
                wait_reg <= wait_reg - 5'h1;
            end
            // read data valid one cycle after strobe
            if (ram_rd_out) begin
                rd_pend_reg <= 1'b1;
            end else if (rd_pend_reg && state_reg == dec_pkg::DEC_KEY) begin
                // step key index
                rd_pend_reg <= 1'b0;
                idx_reg     <= idx_reg + 3'h1;
            end
            // data stands one cycle
            if (rd_pend_reg && state_reg == dec_pkg::DEC_DATA
                && wait_reg == (`DEC_ROUND_CYCLES - 5'h1)) begin
                data_reg <= ram_rdata_in;
            end
            // round over, write back
            if (rd_pend_reg && state_reg == dec_pkg::DEC_DATA && wait_reg == 5'h00) begin
                rd_pend_reg <= 1'b0;
            end
            // round wait per read
            if (data_rd) begin
                wait_reg <= `DEC_ROUND_CYCLES - 5'h1;
            end
            // next byte
            if (byte_done) begin
                byte_reg <= byte_reg + 8'h01;
            end
        end
    end

    // key bytes held between runs
    // no reset, fetch fills it
    always_ff @(posedge core_clk_in) begin
        if (rd_pend_reg && state_reg == dec_pkg::DEC_KEY) begin
            key_store[idx_reg] <= ram_rdata_in;
        end
    end
    assign key_load_out  = rd_pend_reg && (state_reg == dec_pkg::DEC_KEY);
    assign key_index_out = idx_reg;
    assign key_byte_out  = ram_rdata_in;

    // =====================================================
    // software registers
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            // reset values
            start_reg    <= 1'b0;
            ie_reg       <= 1'b0;
            reload_reg   <= 1'b0;
            mode_reg     <= 1'b0;
            dir_reg      <= 1'b0;
            triple_reg   <= 1'b0;
            key_ptr_reg  <= `DEC_RST_BYTE;
            data_ptr_reg <= `DEC_RST_BYTE;
            count_reg    <= `DEC_RST_BYTE;
            mask_reg     <= 2'h0;
            ext_en_reg   <= 1'b0;
            rdata_reg    <= `DEC_RST_BYTE;
        end else begin
            // start set by a one, cleared only at run end
            if (ev_done) begin
                start_reg <= 1'b0;
            end else if (go) begin
                start_reg <= 1'b1;
            end
            // configuration frozen while busy
            if (wr_ctrl && !start_reg) begin
                ie_reg     <= reg_wdata_in[`DEC_BIT_IE];
                reload_reg <= reg_wdata_in[`DEC_BIT_RELOAD];
                mode_reg   <= reg_wdata_in[`DEC_BIT_MODE];
                dir_reg    <= reg_wdata_in[`DEC_BIT_DIR];
                triple_reg <= reg_wdata_in[`DEC_BIT_TRIPLE];
            end
            // frozen while busy
            if (wr_key && !start_reg) begin
                key_ptr_reg <= reg_wdata_in;
            end
            if (wr_data && !start_reg) begin
                data_ptr_reg <= reg_wdata_in;
            end
            if (wr_cnt && !start_reg) begin
                count_reg <= reg_wdata_in;
            end
            // always writable
            if (wr_mask) begin
                mask_reg <= reg_wdata_in[1:0];
            end
            if (wr_ext) begin
                ext_en_reg <= reg_wdata_in[0];
            end
            // data only after a read
            rdata_reg <= reg_rd_in ? rd_mux : `DEC_RST_BYTE;
        end
    end

    // =====================================================
    // outputs
    // levels from registers
    assign reg_rdata_out = rdata_reg;
    assign mode_cfb_out  = mode_reg;
    assign decrypt_out   = dir_reg;
    // start doubles as busy
    assign busy_out      = start_reg;
    // shared enable needed on the line, local enable on the done flag terms only
    assign irq_out = ext_en_reg && ((ie_reg && done_flag) || (ext_flag && mask_reg[1])
                     || (done_flag && mask_reg[0] && ie_reg));
endmodule : dec_engine_ctrl
`default_nettype wire

// >>> bench/dec_engine_ctrl_sva.sv
// assertion checker for the cipher control front end
`include "dec_params.svh"
`default_nettype none
module dec_engine_ctrl_sva #(
    parameter int ADDR_W = 11
) (
    input wire logic              core_clk_in,   // core clock
    input wire logic              rst_n_in,      // sync reset, low
    input wire logic [7:0]        reg_addr_in,   // register address
    input wire logic [7:0]        reg_wdata_in,  // write data
    input wire logic              reg_wr_in,     // write strobe
    input wire logic [ADDR_W-1:0] ram_addr_out,  // ram address
    input wire logic              ram_rd_out,    // ram read strobe
    input wire logic              ram_wr_out,    // ram write strobe
    input wire logic              ram_stall_in,  // ram busy
    input wire logic              key_load_out,  // key byte strobe
    input wire logic [2:0]        key_index_out, // key byte index
    input wire logic              mode_cfb_out,  // feedback mode
    input wire logic              decrypt_out,   // direction
    input wire logic              busy_out,      // run in progress
    input wire logic              irq_out        // interrupt level
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    // ==========================================
    // helpers
    logic              start_wr;     // start write taken while idle
    logic [ADDR_W-1:0] last_rd_reg;  // address of last ram read
    assign start_wr = reg_wr_in && reg_addr_in == `DEC_OFF_CONTROL
                      && reg_wdata_in[0] && !busy_out;
    // remember where the engine last read
    always_ff @(posedge core_clk_in) begin
        if (ram_rd_out && !ram_stall_in) begin
            last_rd_reg <= ram_addr_out;
        end
    end
    // ==========================================
    // properties
    a_start_busy: assert property (start_wr |=> busy_out)
        else $error("start did not raise busy");
    a_idle_quiet: assert property (!busy_out |-> !ram_rd_out && !ram_wr_out && !key_load_out)
        else $error("ram or key traffic while idle");
    a_busy_hold: assert property (busy_out && !ram_wr_out |=> busy_out)
        else $error("busy dropped without a write back");
    a_mode_sel: assert property (start_wr |=> mode_cfb_out == $past(reg_wdata_in[3]))
        else $error("feedback mode differs from control");
    a_dir_sel: assert property (start_wr |=> decrypt_out == $past(reg_wdata_in[2]))
        else $error("direction differs from control");
    a_no_reload: assert property (start_wr && !reg_wdata_in[4] |=> (!key_load_out) [*8])
        else $error("key fetched without reload");
    a_key_fetch: assert property (start_wr && reg_wdata_in[4] |-> ##[1:200] key_load_out)
        else $error("reload fetched no key");
    a_key_range: assert property (key_load_out |-> key_index_out < 3'h7 && busy_out)
        else $error("key index out of range");
    a_wback_place: assert property (ram_wr_out && !ram_stall_in |-> ram_addr_out == last_rd_reg)
        else $error("write back not in place");
    a_irq_hold: assert property (irq_out && !reg_wr_in |=> irq_out)
        else $error("interrupt dropped without a write");
endmodule : dec_engine_ctrl_sva
bind dec_engine_ctrl dec_engine_ctrl_sva #(.ADDR_W(ADDR_W)) u_sva (
    .core_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .ram_addr_out,
    .ram_rd_out, .ram_wr_out, .ram_stall_in, .key_load_out, .key_index_out,
    .mode_cfb_out, .decrypt_out, .busy_out, .irq_out
);
`default_nettype wire

// >>> bench/dec_ram_model.sv
// external ram shared with the cpu, seen by the cipher engine
`default_nettype none
module dec_ram_model (
    input  wire logic        clk_in,    // core clock
    input  wire logic        slow_in,   // cpu contends for ram
    input  wire logic [10:0] addr_in,   // ram address
    input  wire logic        rd_in,     // read strobe
    input  wire logic        wr_in,     // write strobe
    input  wire logic [7:0]  wdata_in,  // write data
    output logic      [7:0]  rdata_out, // read data, next cycle
    output logic             stall_out  // ram busy with cpu
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:2047];  // ram contents
    logic [1:0] cyc_reg = 2'h0;  // contention phase
    // fill with a known pattern
    initial begin
        rdata_out = 8'h00;
        stall_out = 1'b0;
        for (int i = 0; i < 2048; i++) begin
            mem[i] = 8'(i) ^ 8'h5a;
        end
    end
    // stale read data is inverted each cycle, so it matches the read value again on every second cycle
    always @(posedge clk_in) begin
        cyc_reg <= cyc_reg + 2'h1;
        stall_out <= slow_in && cyc_reg == 2'h3;
        rdata_out <= ~rdata_out;
        if (rd_in && !stall_out) begin
            rdata_out <= mem[addr_in];
        end
        if (wr_in && !stall_out) begin
            mem[addr_in] <= wdata_in;
        end
    end
endmodule : dec_ram_model
`default_nettype wire

// >>> bench/tb_top.sv
// testbench for the cipher control front end
`include "dec_params.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk_in = 1'b0;                // core clock
    logic        rst_n_in = 1'b0;                   // sync reset, low
    logic [7:0]  reg_addr_in = 8'h00;               // register address
    logic [7:0]  reg_wdata_in = 8'h00;              // write data
    logic        reg_wr_in = 1'b0;                  // write strobe
    logic        reg_rd_in = 1'b0;                  // read strobe
    logic        slow = 1'b0;                       // ram contention on
    logic [7:0]  reg_rdata_out, ram_wdata_out, ram_rdata_in, key_byte_out;
    logic [10:0] ram_addr_out;                      // ram address
    logic        ram_rd_out, ram_wr_out, ram_stall_in, key_load_out;
    logic        mode_cfb_out, decrypt_out, busy_out, irq_out;
    logic [2:0]  key_index_out;                     // key byte index
    int          failures = 0;                      // mismatches
    int          checks = 0;                        // comparisons
    int          seed = 32'h25e20283;               // fixed seed
    int          wn, kn;                            // writes and key bytes seen
    logic [7:0]  kp, dp;                            // key and data pointers
    always #2.5 core_clk_in = ~core_clk_in;
    dec_engine_ctrl dut (
        .core_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
        .reg_rd_in, .reg_rdata_out, .ram_addr_out, .ram_rd_out, .ram_wr_out,
        .ram_wdata_out, .ram_rdata_in, .ram_grant_in_n_unused_out(), .ram_stall_in,
        .key_load_out, .key_index_out, .key_byte_out, .mode_cfb_out,
        .decrypt_out, .busy_out, .irq_out
    );
    dec_ram_model u_ram (
        .clk_in(core_clk_in), .slow_in(slow), .addr_in(ram_addr_out),
        .rd_in(ram_rd_out), .wr_in(ram_wr_out), .wdata_in(ram_wdata_out),
        .rdata_out(ram_rdata_in), .stall_out(ram_stall_in)
    );
    // ==========================================
    // compare, bus and closing tasks
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        reg_rd_in <= 1'b0;
        @(posedge core_clk_in);
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        reg_wr_in <= 1'b0;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1 v = reg_rdata_out;
        @(posedge core_clk_in);
    endtask : reg_rd
    task automatic idle;
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
        @(posedge core_clk_in);
    endtask : idle
    task automatic wrap_up;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    // ==========================================
    // expectations
    function automatic logic [7:0] ctl(input int i, input logic go);
        return {1'b0, i != 2, 1'b0, i != 1, i[0], i[1], 1'b0, go};
    endfunction : ctl
    function automatic logic [10:0] nbytes(input logic [7:0] c);
        return (c == 8'h00) ? 11'h100 : {3'h0, c};
    endfunction : nbytes
    // ram writes and key bytes, sampled away from the edge
    always @(negedge core_clk_in) begin
        if (ram_wr_out === 1'b1 && ram_stall_in === 1'b0) begin
            check(ram_addr_out, {dp, 3'h0} + 11'(wn));
            check(ram_wdata_out, u_ram.mem[ram_addr_out]);
            wn++;
        end
        if (key_load_out === 1'b1) begin
            check(key_byte_out, u_ram.mem[{kp, key_index_out}]);
            check(key_index_out, kn[2:0]);
            kn++;
        end
    end
    // watchdog
    initial begin
        repeat (40000) @(posedge core_clk_in);
        failures++;
        wrap_up;
    end
    // ==========================================
    // main sequence
    initial begin
        logic [7:0] v, cnt;
        repeat (16) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        @(posedge core_clk_in);
        for (int a = 8'hc3; a < 8'hc8; a++) begin
            reg_rd(8'(a), v);
            check(v, 8'h00);
        end
        kp = 8'($random(seed));
        dp = kp ^ 8'h80;
        reg_wr(`DEC_OFF_KEY_PTR, kp);
        reg_wr(`DEC_OFF_DATA_PTR, dp);
        reg_wr(`DEC_OFF_IRQ_MASK, 8'h00);
        reg_rd(`DEC_OFF_KEY_PTR, v);
        check(v, kp);
        reg_rd(`DEC_OFF_DATA_PTR, v);
        check(v, dp);
        $display("test registers done");
        for (int i = 0; i < 5; i++) begin
            cnt = (i == 2) ? 8'h00 : (i == 3) ? 8'h01 : (8'($random(seed)) & 8'h0f) | 8'h02;
            slow <= i[0];
            wn = 0;
            kn = 0;
            reg_wr(`DEC_OFF_BYTE_COUNT, cnt);
            reg_wr(`DEC_OFF_EXT_ENABLE, {7'h00, i != 3});
            reg_wr(`DEC_OFF_CONTROL, ctl(i, 1'b1) | 8'h80);
            reg_wr(`DEC_OFF_CONTROL, 8'h00);
            idle;
            #1 check(busy_out, 1'b1);
            check(mode_cfb_out, i[0]);
            check(decrypt_out, i[1]);
            for (int t = 0; t < 12000 && busy_out !== 1'b0; t++) @(posedge core_clk_in);
            #1 check(busy_out, 1'b0);
            check(11'(wn), nbytes(cnt));
            check(11'(kn), (i != 1) ? 11'h7 : 11'h0);
            reg_rd(`DEC_OFF_CONTROL, v);
            check(v, ctl(i, 1'b0) | 8'h20);
            check(irq_out, i != 2 && i != 3);
            reg_rd(`DEC_OFF_IRQ_STATUS, v);
            check(v[1], i != 2);
            reg_wr(`DEC_OFF_IRQ_STATUS, 8'h02);
            reg_rd(`DEC_OFF_IRQ_STATUS, v);
            check(v, 8'h01);
            check(irq_out, i != 2 && i != 3);
            reg_wr(`DEC_OFF_CONTROL, ctl(i, 1'b0));
            idle;
            #1 check(irq_out, 1'b0);
            $display("test run %0d done", i);
        end
        wrap_up;
    end
endmodule : tb_top
`default_nettype wire
